// file: rtl/ufb_pkg.sv
// Constants, types and register map of the frame and baud configuration block.
// Assumes one clock domain and a byte-wide register port with 4-bit addresses.
// Overview of operation
// - Mode bit 0 selects seven or eight bits.
// - Mode bit 1 selects one or two stops.
// - Mode bit 2 selects odd or even parity.
// - Mode bit 3 enables parity generation and check.
// - Mode bit 4 gates transmit on clear-to-send.
// - Channel mode 00 runs both directions independently.
// - Channel mode 01 echoes received data back.
// - Mode 10 local loopback, 11 remote loopback.
// - Mode register clears on reset; bit5 reads one.
// - Clock select bit 7 picks baud source.
// - Internal source is system clock divided four.
// - Rate codes pick divisors 65536 down to 256.
// - Reference clocks yield 75 to 19200 baud.
// - Clock select clears on reset; bit3 reads one.
package ufb_pkg;
    // Register port.
    localparam int UFB_ADDR_W = 4;
    localparam int UFB_DATA_W = 8;
    localparam logic [UFB_ADDR_W-1:0] UFB_OFS_MODE = 4'h1;
    localparam logic [UFB_ADDR_W-1:0] UFB_OFS_CSR = 4'h5;
    localparam logic [UFB_DATA_W-1:0] UFB_MODE_RST = 8'h00;
    localparam logic [UFB_DATA_W-1:0] UFB_CSR_RST = 8'h00;
    localparam logic [UFB_DATA_W-1:0] UFB_MODE_ONES = 8'h20;
    localparam logic [UFB_DATA_W-1:0] UFB_CSR_ONES = 8'h08;
    localparam logic [UFB_DATA_W-1:0] UFB_RD_IDLE = 8'h00;
    // Field positions.
    localparam int UFB_M_LEN = 0;
    localparam int UFB_M_STOP = 1;
    localparam int UFB_M_PSENSE = 2;
    localparam int UFB_M_PEN = 3;
    localparam int UFB_M_CTS = 4;
    localparam int UFB_M_CH_LO = 6;
    localparam int UFB_CH_W = 2;
    localparam int UFB_C_SRC = 7;
    localparam int UFB_C_RX_LO = 4;
    localparam int UFB_C_TX_LO = 0;
    localparam int UFB_RATE_W = 3;
    // Baud source prescaler.
    localparam int UFB_PRESCALE = 4;
    localparam int UFB_PRE_W = 2;
    localparam logic [UFB_PRE_W-1:0] UFB_PRE_LAST = UFB_PRE_W'(UFB_PRESCALE - 1);
    localparam logic [UFB_PRE_W-1:0] UFB_PRE_RST = 2'h0;
    localparam int UFB_DIV_W = 16;
    // Frame composition in bits.
    localparam int UFB_FRM_W = 4;
    localparam logic [UFB_FRM_W-1:0] UFB_START_BITS = 4'h1;
    localparam logic [UFB_FRM_W-1:0] UFB_DATA7 = 4'h7;
    localparam logic [UFB_FRM_W-1:0] UFB_DATA8 = 4'h8;
    localparam logic [UFB_FRM_W-1:0] UFB_STOP1 = 4'h1;
    localparam logic [UFB_FRM_W-1:0] UFB_STOP2 = 4'h2;
    localparam logic [UFB_FRM_W-1:0] UFB_PAR_BITS = 4'h1;
    localparam logic [UFB_FRM_W-1:0] UFB_NO_BITS = 4'h0;
    localparam logic [UFB_FRM_W-1:0] UFB_FRAME_RST = 4'h9;
    localparam logic UFB_MARK = 1'b1;

    typedef enum logic [UFB_CH_W-1:0] {
        UFB_CH_NORMAL,
        UFB_CH_ECHO,
        UFB_CH_LOCAL,
        UFB_CH_REMOTE
    } ufb_chan_t;

    // Last count of each rate divisor; the 4.9152 MHz source gives 75..19200 baud.
    function automatic logic [UFB_DIV_W-1:0] ufb_div_last(input logic [UFB_RATE_W-1:0] code);
        case (code)
            3'h0: ufb_div_last = 16'hFFFF;
            3'h1: ufb_div_last = 16'h7FFF;
            3'h2: ufb_div_last = 16'h3FFF;
            3'h3: ufb_div_last = 16'h0FFF;
            3'h4: ufb_div_last = 16'h07FF;
            3'h5: ufb_div_last = 16'h03FF;
            3'h6: ufb_div_last = 16'h01FF;
            default: ufb_div_last = 16'h00FF;
        endcase
    endfunction
endpackage

// file: rtl/ufb_baud_if.sv
// Link between the configuration logic and one bit rate divider.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ufb_baud_if;
    logic srcTick;
    logic clear;
    logic [ufb_pkg::UFB_RATE_W-1:0] rateCode;
    logic bitTick;
    modport gen (input srcTick, input clear, input rateCode, output bitTick);
    modport ctl (output srcTick, output clear, output rateCode, input bitTick);
endinterface
`default_nettype wire

// file: rtl/ufb_baud_gen.sv
// One bit rate divider: counts source ticks and pulses once per bit time.
// Assumes source ticks are one-cycle pulses on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module ufb_baud_gen
    import ufb_pkg::*;
#(
    parameter int DIV_W = UFB_DIV_W
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Divider link
    ufb_baud_if.gen bif
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } ufb_gen_t;

    ufb_gen_t st_ff;
    ufb_gen_t nxt_st;
    logic [DIV_W-1:0] divLast;

    assign divLast = DIV_W'(ufb_div_last(bif.rateCode));

    // A raised rate code mid-period wraps at once instead of running the long way round.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (bif.clear) begin
            nxt_st.cnt = '0;
        end else if (bif.srcTick) begin
            if (st_ff.cnt >= divLast) begin
                nxt_st.cnt = '0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    assign bif.bitTick = st_ff.tick;

    // The last source tick of a period must produce the bit pulse.
    rate_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && bif.srcTick && !bif.clear && st_ff.cnt >= divLast |=> bif.bitTick && st_ff.cnt == '0)
        else $error("bit pulse missing at divisor end");

    // A new bit pulse always follows an enabled source tick; a frozen pulse is not new.
    tick_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(bif.bitTick) |-> $past(bif.srcTick) && $past(clkEn) && !$past(bif.clear))
        else $error("bit pulse without source tick");
endmodule
`default_nettype wire

// file: rtl/uart_frame_and_baud_config.sv
// Frame format, channel mode routing and baud source selection of the serial port.
// Assumes neighbouring shifters consume the registered configuration and bit ticks.
`timescale 1ns/1ps
`default_nettype none
module uart_frame_and_baud_config
    import ufb_pkg::*;
(
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic cpuResetReq,
    // Register port
    input wire logic [UFB_ADDR_W-1:0] regAddr,
    input wire logic [UFB_DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [UFB_DATA_W-1:0] regRdData,
    // Baud clock pin
    input wire logic ext_baud_clock_in,
    // Serial lines and shifter side
    input wire logic rxdPin,
    input wire logic txShiftOut,
    output logic txdPin,
    output logic rxShiftIn,
    // Transmit gating
    input wire logic clear_to_send_low,
    input wire logic txCharReady,
    output logic txStartOk,
    // Frame configuration to shifters
    output logic charEightBits,
    output logic twoStopBits,
    output logic parityEnable,
    output logic parityEven,
    output logic [UFB_FRM_W-1:0] frameBitCount,
    // Bit rate ticks
    output logic rxBitTick,
    output logic txBitTick
);
    typedef struct packed {
        // Software sees these two.
        logic [UFB_DATA_W-1:0] modeReg;
        logic [UFB_DATA_W-1:0] csrReg;
        // These count and watch the source.
        logic [UFB_PRE_W-1:0] preCnt;
        logic extPrev;
        // Read data last one cycle.
        logic [UFB_DATA_W-1:0] rdData;
        // Lines leave through flops.
        logic txd;
        logic rxIn;
        // These follow the mode register.
        logic txOk;
        logic eight;
        logic twoStop;
        logic parEn;
        logic parEven;
        logic [UFB_FRM_W-1:0] frameBits;
        // Ticks leave a cycle late.
        logic rxTick;
        logic txTick;
    } ufb_top_t;

    ufb_top_t st_ff;
    ufb_top_t nxt_st;
    ufb_chan_t chan;
    logic srcTick;

    ufb_baud_if rxIf ();
    ufb_baud_if txIf ();

    // Decoded channel mode.
    assign chan = ufb_chan_t'(st_ff.modeReg[UFB_M_CH_LO +: UFB_CH_W]);

    // Source tick: system clock over four, or a rising edge of the external pin.
    // The pin is far slower than the clock, so a single edge register suffices.
    always_comb begin
        if (st_ff.csrReg[UFB_C_SRC]) begin
            srcTick = ext_baud_clock_in && !st_ff.extPrev;
        end else begin
            srcTick = (st_ff.preCnt == UFB_PRE_LAST);
        end
    end

    // Both dividers share the source; each takes its own rate field.
    assign rxIf.srcTick = srcTick;
    assign rxIf.clear = cpuResetReq;
    assign rxIf.rateCode = st_ff.csrReg[UFB_C_RX_LO +: UFB_RATE_W];
    assign txIf.srcTick = srcTick;
    assign txIf.clear = cpuResetReq;
    assign txIf.rateCode = st_ff.csrReg[UFB_C_TX_LO +: UFB_RATE_W];

    ufb_baud_gen #(
        .DIV_W(UFB_DIV_W)
    ) rxGen (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .bif(rxIf)
    );

    ufb_baud_gen #(
        .DIV_W(UFB_DIV_W)
    ) txGen (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .bif(txIf)
    );

    // Next-state logic for registers, prescaler, routing and frame outputs.
    always_comb begin
        nxt_st = st_ff;
        // The prescaler runs on either source; gating it would save little.
        // The pin level is kept so an edge shows up in the cycle the pin first reads high.
        nxt_st.preCnt = st_ff.preCnt + 1'b1;
        nxt_st.extPrev = ext_baud_clock_in;

        // Read data stand for one cycle only; unmapped addresses read zero.
        nxt_st.rdData = UFB_RD_IDLE;
        if (regRdEn) begin
            if (regAddr == UFB_OFS_MODE) begin
                nxt_st.rdData = st_ff.modeReg | UFB_MODE_ONES;
            end else if (regAddr == UFB_OFS_CSR) begin
                nxt_st.rdData = st_ff.csrReg | UFB_CSR_ONES;
            end
        end

        // Writes are taken in any enabled cycle; the shifters see the change a cycle later.
        if (regWrEn) begin
            if (regAddr == UFB_OFS_MODE) begin
                nxt_st.modeReg = regWrData & ~UFB_MODE_ONES;
            end else if (regAddr == UFB_OFS_CSR) begin
                nxt_st.csrReg = regWrData & ~UFB_CSR_ONES;
            end
        end

        // The reset instruction beats a write in the same cycle.
        if (cpuResetReq) begin
            nxt_st.modeReg = UFB_MODE_RST;
            nxt_st.csrReg = UFB_CSR_RST;
            nxt_st.preCnt = UFB_PRE_RST;
        end

        // Frame format outputs.
        nxt_st.eight = st_ff.modeReg[UFB_M_LEN];
        nxt_st.twoStop = st_ff.modeReg[UFB_M_STOP];
        nxt_st.parEn = st_ff.modeReg[UFB_M_PEN];
        nxt_st.parEven = st_ff.modeReg[UFB_M_PSENSE] && st_ff.modeReg[UFB_M_PEN];
        nxt_st.frameBits = UFB_START_BITS
            + (st_ff.modeReg[UFB_M_LEN] ? UFB_DATA8 : UFB_DATA7)
            + (st_ff.modeReg[UFB_M_PEN] ? UFB_PAR_BITS : UFB_NO_BITS)
            + (st_ff.modeReg[UFB_M_STOP] ? UFB_STOP2 : UFB_STOP1);

        // Clear-to-send gating only matters when enabled in the mode register.
        nxt_st.txOk = txCharReady && (!st_ff.modeReg[UFB_M_CTS] || !clear_to_send_low);

        // Channel mode routing of the serial lines.
        case (chan)
            // Each direction goes its own way.
            UFB_CH_NORMAL: begin
                nxt_st.txd = txShiftOut;
                nxt_st.rxIn = rxdPin;
            end
            // The line comes back and is still received.
            UFB_CH_ECHO: begin
                nxt_st.txd = rxdPin;
                nxt_st.rxIn = rxdPin;
            end
            // The transmitter talks to its own receiver.
            UFB_CH_LOCAL: begin
                nxt_st.txd = UFB_MARK;
                nxt_st.rxIn = txShiftOut;
            end
            // The far end hears itself; the receiver rests.
            default: begin
                nxt_st.txd = rxdPin;
                nxt_st.rxIn = UFB_MARK;
            end
        endcase

        // Bit ticks pass out through a register so every output comes from a flop.
        nxt_st.rxTick = rxIf.bitTick;
        nxt_st.txTick = txIf.bitTick;
    end

    // State register; lines rest at mark and the frame shows its reset length.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.txd <= UFB_MARK;
            st_ff.rxIn <= UFB_MARK;
            st_ff.frameBits <= UFB_FRAME_RST;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register.
    assign regRdData = st_ff.rdData;
    assign txdPin = st_ff.txd;
    assign rxShiftIn = st_ff.rxIn;
    assign txStartOk = st_ff.txOk;
    assign charEightBits = st_ff.eight;
    assign twoStopBits = st_ff.twoStop;
    assign parityEnable = st_ff.parEn;
    assign parityEven = st_ff.parEven;
    assign frameBitCount = st_ff.frameBits;
    assign rxBitTick = st_ff.rxTick;
    assign txBitTick = st_ff.txTick;

    // Character length output follows mode bit 0.
    char_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn |=> charEightBits == $past(st_ff.modeReg[UFB_M_LEN]))
        else $error("character length output wrong");

    // Frame length counts start, data, parity and stop bits.
    frame_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && !st_ff.modeReg[UFB_M_LEN] && !st_ff.modeReg[UFB_M_PEN] && st_ff.modeReg[UFB_M_STOP]
        |=> frameBitCount == UFB_FRAME_RST + UFB_STOP1 && twoStopBits)
        else $error("frame length wrong for two stop bits");

    // Parity sense stays low while parity is off.
    par_sense_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !parityEnable |-> !parityEven)
        else $error("parity sense active with parity off");

    // Parity enable follows mode bit 3 and adds one frame bit.
    par_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn |=> parityEnable == $past(st_ff.modeReg[UFB_M_PEN]))
        else $error("parity enable output wrong");

    // A gated transmitter waits while clear-to-send is high.
    cts_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && st_ff.modeReg[UFB_M_CTS] && clear_to_send_low |=> !txStartOk)
        else $error("transmit started without clear to send");

    // Ungated transmitter starts whenever a character is ready.
    cts_free_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && !st_ff.modeReg[UFB_M_CTS] && txCharReady |=> txStartOk)
        else $error("ungated transmit held off");

    // Normal mode keeps both directions independent.
    chan_normal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && chan == UFB_CH_NORMAL |=> txdPin == $past(txShiftOut) && rxShiftIn == $past(rxdPin))
        else $error("normal mode routing wrong");

    // Auto echo retransmits and still delivers received data.
    chan_echo_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && chan == UFB_CH_ECHO |=> txdPin == $past(rxdPin) && rxShiftIn == $past(rxdPin))
        else $error("auto echo routing wrong");

    // Local loopback feeds the receiver and holds the line at mark.
    chan_local_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && chan == UFB_CH_LOCAL |=> txdPin == UFB_MARK && rxShiftIn == $past(txShiftOut))
        else $error("local loopback routing wrong");

    // Remote loopback returns the line and hides it from the receiver.
    chan_remote_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && chan == UFB_CH_REMOTE |=> txdPin == $past(rxdPin) && rxShiftIn == UFB_MARK)
        else $error("remote loopback routing wrong");

    // The reset instruction clears both registers.
    cpu_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && cpuResetReq |=> st_ff.modeReg == UFB_MODE_RST && st_ff.csrReg == UFB_CSR_RST)
        else $error("reset instruction did not clear registers");

    // Mode read shows the stored bits with the unused bit set.
    mode_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && regRdEn && regAddr == UFB_OFS_MODE |=> regRdData == ($past(st_ff.modeReg) | UFB_MODE_ONES))
        else $error("mode read back wrong");

    // Clock select read shows the stored bits with the unused bit set.
    csr_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && regRdEn && regAddr == UFB_OFS_CSR |=> regRdData == ($past(st_ff.csrReg) | UFB_CSR_ONES))
        else $error("clock select read back wrong");

    // External source ticks only on a rising pin edge.
    ext_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(clkEn) && st_ff.csrReg[UFB_C_SRC] && srcTick |-> !$past(ext_baud_clock_in))
        else $error("external tick without rising edge");

    // Internal source ticks once every four enabled cycles.
    pre_div_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (srcTick && clkEn && !cpuResetReq && !regWrEn && !st_ff.csrReg[UFB_C_SRC])
        ##1 (clkEn && !cpuResetReq && !regWrEn && !st_ff.csrReg[UFB_C_SRC] && !srcTick)[*3]
        |=> srcTick)
        else $error("internal prescaler not dividing by four");

    // Stop bit output follows mode bit 1.
    two_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn |=> twoStopBits == $past(st_ff.modeReg[UFB_M_STOP]))
        else $error("stop bit output wrong");

    // Even parity needs both the sense bit and the enable bit.
    par_even_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn |=> parityEven == ($past(st_ff.modeReg[UFB_M_PSENSE]) && $past(st_ff.modeReg[UFB_M_PEN])))
        else $error("parity sense output wrong");

    // Eight bits, parity and one stop make an eleven-bit frame.
    frame_par_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && st_ff.modeReg[UFB_M_LEN] && st_ff.modeReg[UFB_M_PEN] && !st_ff.modeReg[UFB_M_STOP]
        |=> frameBitCount == UFB_START_BITS + UFB_DATA8 + UFB_PAR_BITS + UFB_STOP1)
        else $error("frame length wrong with parity");

    // A mode write lands without its unused bit.
    mode_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && regWrEn && regAddr == UFB_OFS_MODE && !cpuResetReq
        |=> st_ff.modeReg == ($past(regWrData) & ~UFB_MODE_ONES))
        else $error("mode write lost");

    // A clock select write lands without its unused bit.
    csr_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && regWrEn && regAddr == UFB_OFS_CSR && !cpuResetReq
        |=> st_ff.csrReg == ($past(regWrData) & ~UFB_CSR_ONES))
        else $error("clock select write lost");

    // Read data drop to zero once the strobe is gone.
    // A stale byte would look like a second read to software.
    read_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && !regRdEn |=> regRdData == UFB_RD_IDLE)
        else $error("read data held too long");

    // Each bit tick leaves one cycle after its divider pulse.
    tick_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn |=> rxBitTick == $past(rxIf.bitTick) && txBitTick == $past(txIf.bitTick))
        else $error("bit tick output misplaced");

    // A gated transmitter starts once clear-to-send is low.
    cts_open_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && st_ff.modeReg[UFB_M_CTS] && !clear_to_send_low && txCharReady |=> txStartOk)
        else $error("gated transmit not released");

    // Nothing starts without a character ready.
    no_char_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && !txCharReady |=> !txStartOk)
        else $error("transmit started with no character");

    // The reset instruction restarts the prescaler.
    // Clearing it gives the dividers a known phase afterwards.
    pre_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && cpuResetReq |=> st_ff.preCnt == UFB_PRE_RST)
        else $error("prescaler not cleared");
endmodule
`default_nettype wire

// file: tb/ufb_remote_dev.sv
// Far-end serial device that talks on the receive line of the port.
// Assumes the bench raises sendEn only while it wants traffic on the line.
`timescale 1ns/1ps
`default_nettype none
module ufb_remote_dev (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control and line
    input wire logic sendEn,
    output logic rxdPin
);
    logic [7:0] patFf;

    // Rotate a fixed pattern onto the line; a released line rests at mark, never at the last bit.
    always @(posedge ref_clk) begin
        if (!rst_n || !sendEn) begin
            rxdPin <= 1'b1;
        end else begin
            rxdPin <= patFf[7];
        end
        if (!rst_n) begin
            patFf <= 8'hB4;
        end else if (sendEn) begin
            patFf <= {patFf[6:0], patFf[7]};
        end
    end
endmodule
`default_nettype wire

// file: tb/uart_frame_and_baud_config_tb.sv
// Self-checking bench for the frame and baud configuration block.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module uart_frame_and_baud_config_tb;
    import ufb_pkg::*;
    localparam int DIVS [8] = '{65536, 32768, 16384, 4096, 2048, 1024, 512, 256};
    localparam logic [7:0] FMT [8] = '{8'h01, 8'h02, 8'h04, 8'h0C, 8'h08, 8'h3F, 8'h09, 8'h00};
    logic ref_clk, rst_n, clkEn, cpuResetReq, regWrEn, regRdEn, ext_baud_clock_in;
    logic txShiftOut, clear_to_send_low, txCharReady, sendEn, extRun;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData;
    logic txdPin, rxShiftIn, txStartOk, charEightBits, twoStopBits, parityEnable, parityEven;
    logic rxdPin, rxBitTick, txBitTick;
    logic [3:0] frameBitCount;
    logic [7:0] cyc = 8'h00;
    int fails, cmp_count;

    uart_frame_and_baud_config dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
        .cpuResetReq(cpuResetReq), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .ext_baud_clock_in(ext_baud_clock_in),
        .rxdPin(rxdPin), .txShiftOut(txShiftOut), .txdPin(txdPin), .rxShiftIn(rxShiftIn),
        .clear_to_send_low(clear_to_send_low), .txCharReady(txCharReady), .txStartOk(txStartOk),
        .charEightBits(charEightBits), .twoStopBits(twoStopBits), .parityEnable(parityEnable),
        .parityEven(parityEven), .frameBitCount(frameBitCount), .rxBitTick(rxBitTick),
        .txBitTick(txBitTick));
    ufb_remote_dev far (.ref_clk(ref_clk), .rst_n(rst_n), .sendEn(sendEn), .rxdPin(rxdPin));

    // Free-running clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Transmit shifter stand-in and external baud pin, whose rising edges come every second cycle.
    always @(posedge ref_clk) begin
        cyc <= cyc + 8'h01;
        txShiftOut <= cyc[1];
        ext_baud_clock_in <= extRun & cyc[0];
    end

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask

    // Read data are only valid in the cycle after the strobe, so they are taken there.
    task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(negedge ref_clk);
        chk(what, exp, regRdData);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Cycles between two bit ticks; the first tick may still carry the old rate's phase.
    task automatic measure(input logic useTx, output int n);
        int w;
        w = 0;
        do begin
            @(negedge ref_clk);
            w++;
        end while ((useTx ? txBitTick : rxBitTick) !== 1'b1 && w < 70000);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((useTx ? txBitTick : rxBitTick) !== 1'b1 && n < 70000);
    endtask

    // Hang guard: the tests need about 15000 cycles; it allows 50000.
    initial begin
        #250000;
        fails++;
        end_sim();
    end

    // Main sequence.
    initial begin
        int i, k, n;
        logic r, t;
        {rst_n, cpuResetReq, regWrEn, regRdEn, sendEn, extRun, txCharReady} = '0;
        {regAddr, regWrData} = '0;
        clkEn = 1'b1;
        clear_to_send_low = 1'b1;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("frame bits in reset", 32'h9, frameBitCount);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk("mode reset", UFB_OFS_MODE, 8'h20);
        rdchk("csr reset", UFB_OFS_CSR, 8'h08);
        // Each format field alone and together; parity sense must vanish while parity is off.
        for (i = 0; i < 8; i++) begin
            wr(UFB_OFS_MODE, FMT[i]);
            settle(2);
            chk("eight bits", 32'(FMT[i][0]), charEightBits);
            chk("two stops", 32'(FMT[i][1]), twoStopBits);
            chk("parity even", 32'(FMT[i][2] & FMT[i][3]), parityEven);
            chk("parity on", 32'(FMT[i][3]), parityEnable);
            chk("frame bits", 32'(1 + (FMT[i][0] ? 8 : 7) + FMT[i][3] + (FMT[i][1] ? 2 : 1)), frameBitCount);
            rdchk("mode readback", UFB_OFS_MODE, FMT[i] | 8'h20);
        end
        // Every mix of gating enable, clear-to-send level and character ready.
        for (i = 0; i < 8; i++) begin
            wr(UFB_OFS_MODE, {3'h0, i[2], 4'h0});
            clear_to_send_low <= i[1];
            txCharReady <= i[0];
            settle(2);
            chk("start ok", 32'(i[0] & (!i[2] | !i[1])), txStartOk);
        end
        // Channel modes against the line levels seen one cycle earlier.
        sendEn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(UFB_OFS_MODE, 8'(i << 6));
            settle(3);
            r = rxdPin;
            t = txShiftOut;
            for (k = 0; k < 12; k++) begin
                @(negedge ref_clk);
                chk("txd", 32'(i == 0 ? t : (i == 2 ? 1'b1 : r)), txdPin);
                chk("rx in", 32'(i == 2 ? t : (i == 3 ? 1'b1 : r)), rxShiftIn);
                r = rxdPin;
                t = txShiftOut;
            end
        end
        // Unmapped place, unused bits, then the CPU reset instruction.
        wr(UFB_OFS_MODE, 8'h5B);
        wr(UFB_OFS_CSR, 8'hF7);
        wr(4'h3, 8'hFF);
        rdchk("unmapped", 4'h3, 8'h00);
        rdchk("mode kept", UFB_OFS_MODE, 8'h7B);
        rdchk("csr unused bit", UFB_OFS_CSR, 8'hFF);
        @(posedge ref_clk);
        cpuResetReq <= 1'b1;
        @(posedge ref_clk);
        cpuResetReq <= 1'b0;
        rdchk("mode cpu reset", UFB_OFS_MODE, 8'h20);
        rdchk("csr cpu reset", UFB_OFS_CSR, 8'h08);
        // A write strobed while the clock enable is low is lost.
        @(posedge ref_clk);
        clkEn <= 1'b0;
        wr(UFB_OFS_MODE, 8'h01);
        clkEn <= 1'b1;
        rdchk("mode frozen", UFB_OFS_MODE, 8'h20);
        // Both shifters rest before the rate register is rewritten.
        @(posedge ref_clk);
        sendEn <= 1'b0;
        txCharReady <= 1'b0;
        // Internal source: receiver and transmitter rates set apart from each other.
        for (i = 6; i < 8; i++) begin
            wr(UFB_OFS_CSR, 8'((i << 4) | (13 - i)));
            settle(8);
            measure(1'b0, n);
            chk("rx period", 32'(4 * DIVS[i]), n);
            measure(1'b1, n);
            chk("tx period", 32'(4 * DIVS[13 - i]), n);
        end
        // External source: one source tick per pin rising edge, no prescale.
        extRun <= 1'b1;
        wr(UFB_OFS_CSR, 8'hF7);
        settle(8);
        measure(1'b0, n);
        chk("rx ext period", 32'(2 * DIVS[7]), n);
        measure(1'b1, n);
        chk("tx ext period", 32'(2 * DIVS[7]), n);
        end_sim();
    end
endmodule
`default_nettype wire
